// ---- rtl/ssc_pkg.sv ----
// constants for the synthesizer serial control logic
// assumes one 40 MHz pclk and an apb master for housekeeping access
package ssc_pkg;
   // clock and adapt timer unit
   localparam int unsigned CLK_HZ          = 40_000_000; // pclk rate
   localparam int unsigned ADAPT_UNIT_NS   = 8000;       // one timer step
   localparam int unsigned ADAPT_UNIT_CYC  =
      (ADAPT_UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned TMR_W           = 12;         // adapt timer width
   // burst lengths
   localparam logic [5:0]  LEN_C           = 6'h08;
   localparam logic [5:0]  LEN_HR          = 6'h10;
   localparam logic [5:0]  LEN_N           = 6'h18;
   localparam logic [5:0]  LEN_ADDR        = 6'h20;
   localparam logic [5:0]  LEN_OVER        = 6'h21;      // saturated count
   // address nibble values in addressed bursts
   localparam logic [3:0]  AN_CTRL         = 4'h0;
   localparam logic [3:0]  AN_REFH         = 4'h1;
   localparam logic [3:0]  AN_MAIN         = 4'h2;
   localparam logic [3:0]  AN_DAC          = 4'h3;
   localparam logic [3:0]  AN_SECH         = 4'h4;
   localparam logic [3:0]  AN_SECR         = 4'h5;
   // control register bit positions
   localparam int unsigned C_SEC_STBY      = 0;
   localparam int unsigned C_MAIN_STBY     = 1;          // main_loop_standby
   localparam int unsigned C_REF_STBY      = 2;
   localparam int unsigned C_PUMP_FLOAT    = 3;
   localparam int unsigned C_SEC_FLOAT     = 4;
   localparam int unsigned C_OPEN_DRAIN    = 5;          // open_drain_ctl
   localparam int unsigned C_OUTB_LVL      = 6;
   localparam int unsigned C_OUTA_LVL      = 7;
   // main divider register fields
   localparam int unsigned N_DIV_W         = 18;
   localparam int unsigned N_PMODE_LO      = 18;         // 2-bit pump mode
   localparam int unsigned N_ADAPT_LO      = 20;         // 2-bit timer code
   localparam int unsigned N_LOCK_WIN      = 22;         // main_lock_window_sel
   localparam int unsigned N_FOUT_SEL      = 23;
   // secondary reference register fields
   localparam int unsigned RS_MULT_LO      = 16;         // 2-bit mult mode
   localparam int unsigned RS_REFR_LO      = 18;         // 2-bit refresh div
   localparam int unsigned RS_OUTA_LO      = 20;         // 2-bit output a sel
   localparam int unsigned RS_ALT_EN       = 22;
   // reset values
   localparam logic [7:0]  C_RST           = 8'h02;      // main loop standby
   localparam logic [15:0] D_RST           = 16'h0000;   // dacs zero scale
   // apb byte addresses
   localparam logic [7:0]  A_CTRL          = 8'h00;
   localparam logic [7:0]  A_REFH          = 8'h04;
   localparam logic [7:0]  A_MAIN          = 8'h08;
   localparam logic [7:0]  A_DAC           = 8'h0c;
   localparam logic [7:0]  A_SECH          = 8'h10;
   localparam logic [7:0]  A_SECR          = 8'h14;
   localparam logic [7:0]  A_RACT          = 8'h18;
   localparam logic [7:0]  A_NSACT         = 8'h1c;
   localparam logic [7:0]  A_STAT          = 8'h20;
   localparam logic [7:0]  A_ALTR          = 8'h24;
   localparam logic [7:0]  A_ALTN          = 8'h28;
endpackage

// ---- rtl/ssc_top.sv ----
// serial control logic of a dual-loop synthesizer: three-wire load port,
// double-buffered dividers, pump, lock, dac and output control, apb access
// assumes serial pins are already synchronous to pclk and sclk is far slower
//
// Functional notes
// - msb first, shift on sclk rising edge
// - select rising moves word to target register
// - 8/16/24 bit bursts load ctrl, refhold, main
// - 32 bit burst decoded by address nibble
// - dac, sec holds only through addressed bursts
// - main write copies ref hold to active
// - main write copies sec hold to active
// - select high with sclk low resynchronises
// - main bits pick pump current mode
// - control bit floats both main pumps
// - adapt timer: high pump, then low
// - timer expiry may engage alternate dividers
// - secondary detector output can be floated
// - main lock window bit, secondary fixed
// - loop lock high only while locked
// - lock is AND of active loops
// - lock indicator low after reset
// - dac codes from dac reg, zero is lowpower
// - output b two bits, output c one
// - refresh divider set by sec reference bits
// - keep-alive refresh when ref asleep, unless multiplier inactive
// - address nibble map 0..5, 32 clocks
// - select high blocks shifting
// - open drain low on 0, float on 1
// - main standby floats output b
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module ssc_top #(
   parameter int unsigned ADAPT_UNIT_CYC = ssc_pkg::ADAPT_UNIT_CYC
) (
   input  wire logic        pclk,              // 40 MHz clock
   input  wire logic        presetn,           // async reset, active low
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb access phase
   input  wire logic        pwrite,            // apb direction
   input  wire logic [7:0]  paddr,             // apb byte address
   input  wire logic [31:0] pwdata,            // apb write data
   output logic      [31:0] prdata,            // apb read data
   output logic             pready,            // apb ready
   output logic             pslverr,           // apb error on unmapped
   input  wire logic        enb_n,             // port select, active low
   input  wire logic        sdin,              // serial data
   input  wire logic        sclk,              // serial clock
   input  wire logic        main_lock,         // main loop lock detect
   input  wire logic        sec_lock,          // secondary loop lock detect
   output logic      [15:0] main_ref_div,      // active main reference div
   output logic      [17:0] main_loop_div,     // active main loop div
   output logic      [15:0] sec_ref_div,       // secondary reference div
   output logic      [15:0] sec_loop_div,      // active secondary loop div
   output logic             pump_high_current, // high pump driving
   output logic             pump_low_current,  // low pump driving
   output logic             sec_detector_oe_n, // sec detector enable, low on
   output logic             main_lock_window_sel, // main lock window choice
   output logic             lock_indicator,    // combined lock
   output logic      [7:0]  dac1_code,         // dac 1 code
   output logic      [7:0]  dac2_code,         // dac 2 code
   output logic             dac1_lowpower,     // dac 1 in low power
   output logic             dac2_lowpower,     // dac 2 in low power
   output logic             main_standby,      // main loop in standby
   output logic             sec_standby,       // secondary loop in standby
   output logic             out_a_level,       // general output a level
   output logic      [1:0]  out_a_sel,         // output a function select
   output logic             out_b_o,           // output b level
   output logic             out_b_oe_n,        // output b enable, low on
   output logic             out_c_o,           // open-drain level, always 0
   output logic             out_c_oe_n,        // open-drain enable, low on
   output logic      [1:0]  refresh_div_sel,   // multiplier refresh divider
   output logic             refresh_from_ref,  // refresh from reference osc
   output logic             keepalive_en       // keep-alive osc running
);
   // refuse timer units that overflow the timer at the largest code
   if (ADAPT_UNIT_CYC == 0 || 3 * ADAPT_UNIT_CYC >= (1 << ssc_pkg::TMR_W))
      $error("ssc_top: ADAPT_UNIT_CYC out of range");

   localparam logic [ssc_pkg::TMR_W-1:0] UNIT =
      ssc_pkg::TMR_W'(ADAPT_UNIT_CYC);  // one timer step in cycles

   // whole module state
   typedef struct packed {
      logic [7:0]                ctrl;    // control register
      logic [15:0]               refh;    // ref_hold_reg
      logic [23:0]               mainr;   // main divider register
      logic [15:0]               dac;     // dac register
      logic [15:0]               sech;    // sec_div_hold_reg
      logic [23:0]               secr;    // secondary reference register
      logic [15:0]               r_act;   // active main reference div
      logic [15:0]               ns_act;  // active secondary loop div
      logic [31:0]               shreg;   // serial shift register
      logic [5:0]                cnt;     // bits in current burst
      logic                      enb_p;   // select last cycle
      logic                      sclk_p;  // sclk last cycle
      logic                      desync;  // port out of step
      logic [15:0]               alt_r;   // alternate main reference div
      logic [17:0]               alt_n;   // alternate main loop div
      logic                      use_alt; // alternate set engaged
      logic [ssc_pkg::TMR_W-1:0] tmr;     // adapt timer
      logic                      adapt;   // adapt timer running
      logic                      lock;    // registered lock indicator
      logic [31:0]               rdata;   // apb read data
      logic                      rerr;    // apb error for this access
   } ssc_state_t;

   ssc_state_t s_q;  // registered state
   ssc_state_t s_d;  // next state

   logic       sclk_rise;  // rising sclk edge seen this cycle
   logic       enb_rise;   // select released this cycle
   logic       enb_move;   // select changed this cycle
   logic       map_hit;    // apb address decodes
   logic [1:0] pmode;      // main pump mode bits
   logic [1:0] acode;      // adapt timer code
   logic       main_wr;    // main divider load lands this cycle

   assign sclk_rise = sclk & ~s_q.sclk_p;
   assign enb_rise  = enb_n & ~s_q.enb_p;
   assign enb_move  = enb_n ^ s_q.enb_p;
   assign pmode     = s_q.mainr[ssc_pkg::N_PMODE_LO +: 2];
   assign acode     = s_q.mainr[ssc_pkg::N_ADAPT_LO +: 2];
   assign map_hit   = paddr[1:0] == 2'h0 && paddr <= ssc_pkg::A_ALTN;
   // short 24 bit burst or addressed burst with the main nibble
   assign main_wr   = enb_rise && !s_q.desync
      && (s_q.cnt == ssc_pkg::LEN_N || (s_q.cnt == ssc_pkg::LEN_ADDR
          && s_q.shreg[31:28] == ssc_pkg::AN_MAIN));

   // next state: serial port, register loads, adapt timer, lock, apb
   always_comb begin
      s_d        = s_q;
      s_d.enb_p  = enb_n;
      s_d.sclk_p = sclk;
      // select moved while sclk high: port loses step
      if (enb_move && sclk) begin
         s_d.desync = 1'b1;
      end else if (enb_n && !sclk) begin
         s_d.desync = 1'b0;
      end
      // shift only while selected and in step, msb arrives first
      if (!enb_n && sclk_rise && !s_q.desync) begin
         s_d.shreg = {s_q.shreg[30:0], sdin};
         if (s_q.cnt != ssc_pkg::LEN_OVER) begin
            s_d.cnt = s_q.cnt + 6'h01;
         end
      end
      // adapt timer counts down, then hands over to the low pump
      if (s_q.adapt) begin
         s_d.tmr = s_q.tmr - 1'b1;
         if (s_q.tmr == 1) begin
            s_d.adapt   = 1'b0;
            s_d.use_alt = s_q.secr[ssc_pkg::RS_ALT_EN];
         end
      end
      // select released: move word by length or address nibble
      if (enb_rise) begin
         s_d.cnt = 6'h00;
         if (!s_q.desync) begin
            case (s_q.cnt)
               ssc_pkg::LEN_C:  s_d.ctrl = s_q.shreg[7:0];
               ssc_pkg::LEN_HR: s_d.refh = s_q.shreg[15:0];
               ssc_pkg::LEN_N:  s_d.mainr = s_q.shreg[23:0];
               ssc_pkg::LEN_ADDR: begin
                  case (s_q.shreg[31:28])
                     ssc_pkg::AN_CTRL: s_d.ctrl = s_q.shreg[7:0];
                     ssc_pkg::AN_REFH: s_d.refh = s_q.shreg[15:0];
                     ssc_pkg::AN_MAIN: s_d.mainr = s_q.shreg[23:0];
                     ssc_pkg::AN_DAC:  s_d.dac = s_q.shreg[15:0];
                     ssc_pkg::AN_SECH: s_d.sech = s_q.shreg[15:0];
                     ssc_pkg::AN_SECR: s_d.secr = s_q.shreg[23:0];
                     default: ;  // unused nibbles load nothing
                  endcase
               end
               default: ;  // any other length is dropped
            endcase
            // a main write transfers both holding registers at once
            if (main_wr) begin
               s_d.r_act   = s_q.refh;
               s_d.ns_act  = s_q.sech;
               s_d.use_alt = 1'b0;
               // nonzero adapt code restarts the high pump window
               if (s_q.shreg[ssc_pkg::N_ADAPT_LO +: 2] != 2'h0) begin
                  s_d.adapt = 1'b1;
                  s_d.tmr   = ssc_pkg::TMR_W'(
                     s_q.shreg[ssc_pkg::N_ADAPT_LO +: 2]) * UNIT;
               end else begin
                  s_d.adapt = 1'b0;
               end
            end
         end
      end
      // each loop counts only when awake; both asleep shows unlocked
      s_d.lock = (s_q.ctrl[ssc_pkg::C_MAIN_STBY] | main_lock)
               & (s_q.ctrl[ssc_pkg::C_SEC_STBY] | sec_lock)
               & ~(s_q.ctrl[ssc_pkg::C_MAIN_STBY]
                   & s_q.ctrl[ssc_pkg::C_SEC_STBY]);
      // apb: read data prepared in setup so access phase needs no wait
      if (psel && !penable) begin
         s_d.rerr = ~map_hit;
         case (paddr)
            ssc_pkg::A_CTRL:  s_d.rdata = {24'h0, s_q.ctrl};
            ssc_pkg::A_REFH:  s_d.rdata = {16'h0, s_q.refh};
            ssc_pkg::A_MAIN:  s_d.rdata = {8'h0, s_q.mainr};
            ssc_pkg::A_DAC:   s_d.rdata = {16'h0, s_q.dac};
            ssc_pkg::A_SECH:  s_d.rdata = {16'h0, s_q.sech};
            ssc_pkg::A_SECR:  s_d.rdata = {8'h0, s_q.secr};
            ssc_pkg::A_RACT:  s_d.rdata = {16'h0, s_q.r_act};
            ssc_pkg::A_NSACT: s_d.rdata = {16'h0, s_q.ns_act};
            ssc_pkg::A_STAT:  s_d.rdata = {28'h0, s_q.use_alt, s_q.adapt,
                                           s_q.desync, s_q.lock};
            ssc_pkg::A_ALTR:  s_d.rdata = {16'h0, s_q.alt_r};
            ssc_pkg::A_ALTN:  s_d.rdata = {14'h0, s_q.alt_n};
            default:          s_d.rdata = 32'h0;
         endcase
      end
      // writes land at the access edge; only alternate dividers writable
      if (psel && penable && pwrite) begin
         if (paddr == ssc_pkg::A_ALTR) begin
            s_d.alt_r = pwdata[15:0];
         end else if (paddr == ssc_pkg::A_ALTN) begin
            s_d.alt_n = pwdata[17:0];
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q       <= '0;
         s_q.ctrl  <= ssc_pkg::C_RST;
         s_q.dac   <= ssc_pkg::D_RST;
         s_q.enb_p <= 1'b1;
         s_q.lock  <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // apb answers in the first access cycle
   assign pready  = 1'b1;
   assign prdata  = s_q.rdata;
   assign pslverr = psel & penable & s_q.rerr;

   // divider outputs; alternate pair replaces main pair after expiry
   assign main_ref_div  = s_q.use_alt ? s_q.alt_r : s_q.r_act;
   assign main_loop_div = s_q.use_alt ? s_q.alt_n
                                      : s_q.mainr[ssc_pkg::N_DIV_W-1:0];
   assign sec_ref_div   = s_q.secr[15:0];
   assign sec_loop_div  = s_q.ns_act;

   // pumps: float bit overrides mode; adapt runs high then low
   always_comb begin
      if (s_q.ctrl[ssc_pkg::C_PUMP_FLOAT]) begin
         pump_high_current = 1'b0;
         pump_low_current  = 1'b0;
      end else if (acode != 2'h0) begin
         pump_high_current = s_q.adapt;
         pump_low_current  = ~s_q.adapt;
      end else begin
         pump_high_current = pmode[1];
         pump_low_current  = pmode[0];
      end
   end

   assign sec_detector_oe_n    = s_q.ctrl[ssc_pkg::C_SEC_FLOAT];
   assign main_lock_window_sel = s_q.mainr[ssc_pkg::N_LOCK_WIN];
   assign lock_indicator       = s_q.lock;
   assign main_standby         = s_q.ctrl[ssc_pkg::C_MAIN_STBY];
   assign sec_standby          = s_q.ctrl[ssc_pkg::C_SEC_STBY];

   // dacs sleep at zero scale; reset leaves both there
   assign dac1_code     = s_q.dac[7:0];
   assign dac2_code     = s_q.dac[15:8];
   assign dac1_lowpower = s_q.dac[7:0] == 8'h00;
   assign dac2_lowpower = s_q.dac[15:8] == 8'h00;

   // general outputs
   assign out_a_level = s_q.ctrl[ssc_pkg::C_OUTA_LVL];
   assign out_a_sel   = s_q.secr[ssc_pkg::RS_OUTA_LO +: 2];
   assign out_b_o     = s_q.ctrl[ssc_pkg::C_OUTB_LVL];
   assign out_b_oe_n  = s_q.ctrl[ssc_pkg::C_MAIN_STBY];
   assign out_c_o     = 1'b0;
   assign out_c_oe_n  = s_q.ctrl[ssc_pkg::C_OPEN_DRAIN];

   // multiplier refresh: keep-alive only when ref asleep and mult active
   assign refresh_div_sel  = s_q.secr[ssc_pkg::RS_REFR_LO +: 2];
   assign refresh_from_ref = ~s_q.ctrl[ssc_pkg::C_REF_STBY];
   assign keepalive_en     = s_q.ctrl[ssc_pkg::C_REF_STBY]
      & (s_q.secr[ssc_pkg::RS_MULT_LO +: 2] != 2'h0);

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_shift_gate: assert property (enb_n |=> s_q.shreg == $past(s_q.shreg))
      else $error("shift while deselected");
   a_shift_msb: assert property (!enb_n && sclk_rise && !s_q.desync
      |=> s_q.shreg[0] == $past(sdin))
      else $error("bit not shifted in");
   a_ctrl_load: assert property (enb_rise && !s_q.desync
      && s_q.cnt == ssc_pkg::LEN_C |=> s_q.ctrl == $past(s_q.shreg[7:0]))
      else $error("8 bit burst not loaded");
   a_dac_short: assert property (enb_rise && s_q.cnt != ssc_pkg::LEN_ADDR
      |=> s_q.dac == $past(s_q.dac) && s_q.sech == $past(s_q.sech))
      else $error("short burst touched addressed-only reg");
   a_hold_copy: assert property (enb_rise && !s_q.desync
      && s_q.cnt == ssc_pkg::LEN_N
      |=> s_q.r_act == $past(s_q.refh) && s_q.ns_act == $past(s_q.sech))
      else $error("holding regs not transferred");
   a_odd_drop: assert property (enb_rise && s_q.cnt == 6'h0c
      |=> $stable(s_q.ctrl) && $stable(s_q.mainr) && $stable(s_q.refh))
      else $error("odd burst modified a register");
   a_resync: assert property (enb_n && !sclk |=> !s_q.desync)
      else $error("port did not resynchronise");
   a_pump_float: assert property (s_q.ctrl[ssc_pkg::C_PUMP_FLOAT]
      |-> !pump_high_current && !pump_low_current)
      else $error("pumps not floated");
   // cycles spent in the high pump window since the last main write;
   // a counter, since the window at the default step is far too long
   // to be spelled out as a delay
   logic [ssc_pkg::TMR_W-1:0] adapt_run_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adapt_run_q <= '0;
      end else if (main_wr || !s_q.adapt) begin
         adapt_run_q <= '0;  // a reload starts the window afresh
      end else begin
         adapt_run_q <= adapt_run_q + 1'b1;
      end
   end

   a_adapt_len: assert property ($fell(s_q.adapt) && !$past(main_wr)
      |-> adapt_run_q == ssc_pkg::TMR_W'(acode) * UNIT)
      else $error("adapt window wrong length");
   a_addr_copy: assert property (enb_rise && !s_q.desync
      && s_q.cnt == ssc_pkg::LEN_ADDR && s_q.shreg[31:28] == ssc_pkg::AN_MAIN
      |=> s_q.r_act == $past(s_q.refh) && s_q.ns_act == $past(s_q.sech))
      else $error("addressed main write skipped hold copy");
   a_lock_and: assert property (main_standby && sec_standby
      |=> !lock_indicator)
      else $error("lock high with both loops asleep");
   a_outb_float: assert property (main_standby |-> out_b_oe_n)
      else $error("output b driven in standby");

   c_addr_dac: cover property (enb_rise && s_q.cnt == ssc_pkg::LEN_ADDR
      && s_q.shreg[31:28] == ssc_pkg::AN_DAC);
   c_adapt_end: cover property ($fell(s_q.adapt) ##1 s_q.use_alt);
   c_desync: cover property ($rose(s_q.desync));
   c_locked: cover property ($rose(lock_indicator));
endmodule

// ---- sim/ssc_host.sv ----
// host model of the three-wire load port, sclk still outside bursts
// assumes a free-running pclk; each sclk high phase spans one pclk cycle (three at a glitch), each low phase two
`timescale 1ns/100ps
module ssc_host (
   input  wire logic pclk,  // bench clock
   output logic      enb_n, // port select, active low
   output logic      sdin,  // serial data
   output logic      sclk   // serial clock
);
   // idle: deselected, clock low
   initial begin
      enb_n = 1'b1;
      sdin  = 1'b0;
      sclk  = 1'b0;
   end
   // one burst of n bits; glitch lifts select while sclk is high
   task automatic send(input logic [31:0] w, input int n, input bit glitch);
      @(posedge pclk) enb_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge pclk) sdin <= w[i];
         @(posedge pclk) sclk <= 1'b1;
         if (glitch && i == n / 2) begin
            @(posedge pclk) enb_n <= 1'b1;
            @(posedge pclk) enb_n <= 1'b0;
         end
         @(posedge pclk) sclk <= 1'b0;
      end
      // select is released with sclk low; stale data is not left behind
      @(posedge pclk) enb_n <= 1'b1;
      sdin <= ~sdin;
      repeat (3) @(posedge pclk);
   endtask
endmodule

// ---- sim/synth_serial_control_logic_test.sv ----
// self-checking bench for the synthesizer serial control logic
// assumes ssc_host drives the load port and apb reaches the registers
`timescale 1ns/100ps
module synth_serial_control_logic_test;
   localparam int unsigned ADAPT = 10; // short timer step for simulation
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, sdin, sclk, enb_n, pready, pslverr, err_q;
   logic        main_lock = 1'b0, sec_lock = 1'b0;
   logic [7:0]  paddr = 8'h00, dac1_code, dac2_code;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic [15:0] main_ref_div, sec_ref_div, sec_loop_div;
   logic [17:0] main_loop_div;
   logic [1:0]  out_a_sel, refresh_div_sel;
   logic        pump_high_current, pump_low_current, sec_detector_oe_n;
   logic        main_lock_window_sel, lock_indicator, dac1_lowpower;
   logic        dac2_lowpower, main_standby, sec_standby, out_a_level;
   logic        out_b_o, out_b_oe_n, out_c_o, out_c_oe_n;
   logic        refresh_from_ref, keepalive_en;
   int          errors = 0, n_compared = 0;
   ssc_top #(.ADAPT_UNIT_CYC(ADAPT)) ssc_top_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .enb_n, .sdin, .sclk, .main_lock, .sec_lock, .main_ref_div,
      .main_loop_div, .sec_ref_div, .sec_loop_div, .pump_high_current,
      .pump_low_current, .sec_detector_oe_n, .main_lock_window_sel,
      .lock_indicator, .dac1_code, .dac2_code, .dac1_lowpower,
      .dac2_lowpower, .main_standby, .sec_standby, .out_a_level,
      .out_a_sel, .out_b_o, .out_b_oe_n, .out_c_o, .out_c_oe_n,
      .refresh_div_sel, .refresh_from_ref, .keepalive_en);
   ssc_host ssc_host_inst (.pclk, .enb_n, .sdin, .sclk);
   // 25 ns period
   always #12.5 pclk = ~pclk;
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q  = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd_q, x);
      chk(err_q, 32'h0);
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog: the full sequence needs under two thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(ssc_pkg::A_CTRL, {24'h0, ssc_pkg::C_RST});
      chk({out_b_oe_n, lock_indicator, dac1_lowpower, dac2_lowpower,
           out_c_oe_n, out_c_o}, 32'h2c);
      ssc_host_inst.send(32'h60, 8, 1'b0);
      chk({out_b_oe_n, out_b_o, out_c_oe_n, main_standby}, 32'h6);
      ssc_host_inst.send(32'hfff, 12, 1'b0);
      rd(ssc_pkg::A_CTRL, 32'h60);
      ssc_host_inst.send(32'hff, 8, 1'b1);
      rd(ssc_pkg::A_CTRL, 32'h60);
      ssc_host_inst.send(32'hf0, 8, 1'b0);
      chk({out_a_level, sec_detector_oe_n}, 32'h3);
      ssc_host_inst.send(32'h1234, 16, 1'b0);
      ssc_host_inst.send(32'h4000_0abc, 32, 1'b0);
      chk({main_ref_div, sec_loop_div}, 32'h0);
      rd(ssc_pkg::A_SECH, 32'h0abc);
      ssc_host_inst.send(32'h3000_00a5, 32, 1'b0);
      ssc_host_inst.send(32'h5678, 16, 1'b0);
      chk({dac2_code, dac1_code, dac2_lowpower, dac1_lowpower},
          32'h296);
      for (int m = 0; m < 4; m++) begin
         ssc_host_inst.send(32'h40_0155 | (m << 18), 24, 1'b0);
         chk({pump_high_current, pump_low_current}, m);
      end
      chk({main_lock_window_sel, main_ref_div}, 32'h15678);
      chk({sec_loop_div[13:0], main_loop_div}, {14'h0abc, 18'h155});
      ssc_host_inst.send(32'h78, 8, 1'b0);
      chk({pump_high_current, pump_low_current}, 32'h0);
      apb(1'b1, ssc_pkg::A_ALTR, 32'h0777);
      ssc_host_inst.send(32'h5049_0003, 32, 1'b0);
      ssc_host_inst.send(32'h74, 8, 1'b0);
      chk({keepalive_en, refresh_from_ref, refresh_div_sel}, 32'ha);
      chk({sec_ref_div, out_a_sel}, 32'hc);
      ssc_host_inst.send(32'h30_0155, 24, 1'b0);
      chk({pump_high_current, pump_low_current}, 32'h2);
      repeat (3 * ADAPT + 5) @(posedge pclk);
      chk({pump_high_current, pump_low_current}, 32'h1);
      chk(main_ref_div, 32'h0777);
      for (int i = 0; i < 16; i++) begin
         ssc_host_inst.send(32'h70 | (i & 3), 8, 1'b0);
         main_lock <= i[2];
         sec_lock  <= i[3];
         repeat (2) @(posedge pclk);
         chk({main_standby, sec_standby}, i & 3);
         chk(lock_indicator, (i[1] | i[2]) & (i[0] | i[3]) &
             ~(i[1] & i[0]));
      end
      apb(1'b1, ssc_pkg::A_CTRL, 32'hff);
      rd(ssc_pkg::A_CTRL, 32'h73);
      apb(1'b0, 8'h2c, 32'h0);
      chk(err_q, 32'h1);
      ssc_host_inst.send(32'h1000_0abc, 32, 1'b0);
      ssc_host_inst.send(32'h2000_0155, 32, 1'b0);
      chk({main_ref_div, main_loop_div[15:0]}, 32'h0abc_0155);
      ssc_host_inst.send(32'h0000_0001, 32, 1'b0);
      chk({main_standby, sec_standby}, 32'h1);
      wrap_up();
   end
endmodule
